// ### design/spims_pkg.sv
// Purpose: shared constants for the select-mode serial master port
// Assumes: core clock of 100 MHz; serial clock of 80 ns period
// Notes: reset values of the control bits and timing counts live here
package spims_pkg;
   // core clock period and serial clock half period, in ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCK_HALF_NS = 40;
   // cycles per serial clock half period, rounded down, at least one
   localparam int SCK_HALF_CYC_I = (SCK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCK_HALF_NS / CLK_PERIOD_NS);
   localparam logic [3:0] SCK_HALF_CYC = 4'(SCK_HALF_CYC_I);
   // bits per transfer, index of the last bit
   localparam logic [2:0] BIT_TOP = 3'h7;
   // reset values of the control bits
   localparam logic RST_SELECT_MODE_HI = 1'h0;
   localparam logic RST_SELECT_MODE_LO = 1'h1;
   localparam logic RST_MASTER_ENABLE = 1'h0;
   localparam logic RST_PORT_ENABLE = 1'h0;
   localparam logic [7:0] RST_DATA = 8'h00;
   // transfer engine states
   typedef enum logic [0:0] {SPIMS_IDLE, SPIMS_SHIFT} spims_state_e;
endpackage : spims_pkg

// ### design/spims_sync3.sv
// Purpose: three flip-flop synchroniser for a pin from outside the core clock
// Assumes: the pin is asynchronous to i_core_clk
// Notes: the output moves only when the second and third stages agree
module spims_sync3 (
   input wire logic i_core_clk, // core clock
   input wire logic i_rst, // asynchronous reset, active high
   input wire logic i_rst_level, // value held after reset
   input wire logic i_pin, // raw pin level
   output logic o_level // filtered, synchronised level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic primed;
   } spims_sync_s;

   spims_sync_s st;
   spims_sync_s next_st;

   // first stage feeds only the second; the agree test uses stages two and three
   always_comb
   begin
      next_st = st;
      next_st.s1 = i_pin;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (st.s2 == st.s3)
      begin
         next_st.level = st.s3;
      end
      // reset may load constants only, so the chosen idle level is loaded on the first edge after it
      if (!st.primed)
      begin
         next_st.s2 = i_rst_level;
         next_st.s3 = i_rst_level;
         next_st.level = i_rst_level;
         next_st.primed = 1'h1;
      end
   end

   // reset loads constants only; the chosen level is latched one edge later
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st <= '{s1: 1'h1, s2: 1'h1, s3: 1'h1, level: 1'h1, primed: 1'h0};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_level = st.level;
endmodule : spims_sync3

// ### design/spims_master.sv
// Purpose: byte-wide full-duplex serial master with three slave-select modes
// Assumes: serial clock idles low, data out changes on falling edges, data in taken on falling edges
// Notes: select-mode and enable bits arrive as write strobes with values, interrupt enable as a level; flags clear by pulse, a set in the same cycle wins

// Behaviour
// [RL1] Each finished byte sets the transfer done flag and raises the interrupt when enabled.
// [RL2] The byte shifted out and the byte shifted in move together, so one flag means both done.
// [RL3] Incoming bits enter the shift register top bit first and the whole byte then moves to the receive buffer.
// [RL4] Upper select bit low with lower select bit high, the reset default, is multi-master with select as input.
// [RL5] In multi-master mode a low select input clears both enable bits and sets the mode fault flag.
// [RL6] A mode fault raises the interrupt when enabled and the port stays off until software enables it again.
// [RL7] Both select bits low is three-wire mode, where the select line is ignored and not driven.
// [RL8] Upper select bit high is four-wire mode, where the select line is an output for one slave.
// [RL9] In four-wire mode the select output level follows the lower select bit.
// [RL10] In three-wire mode further slaves are picked by general-purpose pins under software, not by this port.
// [RL11] The master gives eight serial clock cycles per byte and keeps the clock idle between bytes.
module spims_master (
   input wire logic i_core_clk, // core clock, 100 MHz
   input wire logic i_rst, // asynchronous reset, active high
   input wire logic i_start, // pulse: start a byte with i_tx_data
   input wire logic [7:0] i_tx_data, // byte to send
   input wire logic i_mode_wr, // pulse: load both select-mode bits
   input wire logic i_select_mode_hi, // upper select-mode bit value
   input wire logic i_select_mode_lo, // lower select-mode bit value
   input wire logic i_enable_wr, // pulse: load both enable bits
   input wire logic i_master_enable_bit, // master enable value
   input wire logic i_port_enable_bit, // port enable value
   input wire logic i_irq_enable, // level: interrupt enable
   input wire logic i_clr_done, // pulse: clear transfer done flag
   input wire logic i_clr_fault, // pulse: clear mode fault flag
   input wire logic i_miso, // serial data in from slave
   input wire logic i_slave_select, // select pin input level
   output logic o_sck, // serial clock out
   output logic o_mosi, // serial data out
   output logic o_slave_select, // select pin output level
   output logic o_slave_select_oe, // select pin output enable, high drives
   output logic [7:0] o_rx_data, // receive buffer
   output logic o_busy, // transfer in progress
   output logic o_transfer_done_flag, // sticky byte done flag
   output logic o_mode_fault_flag, // sticky mode fault flag
   output logic o_master_enable_bit, // current master enable
   output logic o_port_enable_bit, // current port enable
   output logic o_select_mode_hi, // current upper select-mode bit
   output logic o_select_mode_lo, // current lower select-mode bit
   output logic o_irq // interrupt request, level
);
   typedef struct packed {
      spims_pkg::spims_state_e state;
      logic [3:0] div;
      logic [2:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] rx;
      logic sck;
      logic mosi;
      logic ss;
      logic ss_oe;
      logic done;
      logic fault;
      logic men;
      logic pen;
      logic mhi;
      logic mlo;
      logic irq;
      logic busy;
   } spims_state_s;

   spims_state_s st;
   spims_state_s next_st;
   logic miso_s;
   logic ss_s;
   logic [7:0] shifted;

   // pins from outside the core domain pass three flops
   spims_sync3 u_sync_miso (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_rst_level(1'h1),
      .i_pin(i_miso),
      .o_level(miso_s)
   );

   spims_sync3 u_sync_ss (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_rst_level(1'h1),
      .i_pin(i_slave_select),
      .o_level(ss_s)
   );

   // shift value with the incoming bit appended at the bottom
   // [RL3] top bit first
   assign shifted = {st.shreg[6:0], miso_s};

   // next state of the whole port
   always_comb
   begin
      next_st = st;
      // software control writes
      if (i_mode_wr)
      begin
         next_st.mhi = i_select_mode_hi;
         next_st.mlo = i_select_mode_lo;
      end
      if (i_enable_wr)
      begin
         next_st.men = i_master_enable_bit;
         next_st.pen = i_port_enable_bit;
      end
      // clears first so that a hardware set below overrides them
      if (i_clr_done)
      begin
         next_st.done = 1'h0;
      end
      if (i_clr_fault)
      begin
         next_st.fault = 1'h0;
      end
      // transfer engine
      case (st.state)
         spims_pkg::SPIMS_IDLE:
         begin
            // [RL11] clock idle low
            next_st.sck = 1'h0;
            next_st.div = 4'h0;
            if (i_start && st.men && st.pen)
            begin
               next_st.state = spims_pkg::SPIMS_SHIFT;
               next_st.shreg = i_tx_data;
               next_st.mosi = i_tx_data[7];
               next_st.bitcnt = spims_pkg::BIT_TOP;
            end
         end
         spims_pkg::SPIMS_SHIFT:
         begin
            if (st.div == spims_pkg::SCK_HALF_CYC - 4'h1)
            begin
               next_st.div = 4'h0;
               if (!st.sck)
               begin
                  next_st.sck = 1'h1;
               end
               else
               begin
                  // [RL2] sample in while the same edge advances data out
                  next_st.sck = 1'h0;
                  next_st.shreg = shifted;
                  next_st.mosi = shifted[7];
                  next_st.bitcnt = st.bitcnt - 3'h1;
                  if (st.bitcnt == 3'h0)
                  begin
                     // [RL3] whole byte to receive buffer
                     next_st.rx = shifted;
                     // [RL1] done flag set
                     next_st.done = 1'h1;
                     // [RL11] eighth clock ends the byte
                     next_st.state = spims_pkg::SPIMS_IDLE;
                  end
               end
            end
            else
            begin
               next_st.div = st.div + 4'h1;
            end
         end
         default:
         begin
            next_st.state = spims_pkg::SPIMS_IDLE;
         end
      endcase
      // select pin handling by mode; a write in this cycle takes effect next cycle
      if (st.mhi)
      begin
         // [RL8] four-wire select output
         next_st.ss_oe = 1'h1;
         // [RL9] select follows lower bit
         next_st.ss = st.mlo;
      end
      else
      begin
         // [RL7] three-wire leaves select undriven
         next_st.ss_oe = 1'h0;
         next_st.ss = 1'h1;
         // [RL4] multi-master watches select
         if (st.mlo && !ss_s)
         begin
            // [RL5] fault disables the master
            next_st.men = 1'h0;
            next_st.pen = 1'h0;
            next_st.fault = 1'h1;
            // stopping mid-byte avoids fighting the other master on the clock
            next_st.state = spims_pkg::SPIMS_IDLE;
            next_st.sck = 1'h0;
            next_st.div = 4'h0;
         end
      end
      // [RL6] fault and done both reach the interrupt
      next_st.irq = i_irq_enable && (next_st.done || next_st.fault);
      // busy kept as its own flop so the output needs no decode
      next_st.busy = (next_st.state == spims_pkg::SPIMS_SHIFT);
   end

   // register the whole state; reset loads constants only
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st.state <= spims_pkg::SPIMS_IDLE;
         st.div <= 4'h0;
         st.bitcnt <= 3'h0;
         st.shreg <= spims_pkg::RST_DATA;
         st.rx <= spims_pkg::RST_DATA;
         st.sck <= 1'h0;
         st.mosi <= 1'h0;
         st.ss <= 1'h1;
         st.ss_oe <= 1'h0;
         st.done <= 1'h0;
         st.fault <= 1'h0;
         st.men <= spims_pkg::RST_MASTER_ENABLE;
         st.pen <= spims_pkg::RST_PORT_ENABLE;
         st.mhi <= spims_pkg::RST_SELECT_MODE_HI;
         st.mlo <= spims_pkg::RST_SELECT_MODE_LO;
         st.irq <= 1'h0;
         st.busy <= 1'h0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs straight from the state flops
   assign o_sck = st.sck;
   assign o_mosi = st.mosi;
   assign o_slave_select = st.ss;
   assign o_slave_select_oe = st.ss_oe;
   assign o_rx_data = st.rx;
   assign o_busy = st.busy;
   assign o_transfer_done_flag = st.done;
   assign o_mode_fault_flag = st.fault;
   assign o_master_enable_bit = st.men;
   assign o_port_enable_bit = st.pen;
   assign o_select_mode_hi = st.mhi;
   assign o_select_mode_lo = st.mlo;
   assign o_irq = st.irq;
endmodule : spims_master

// ### dv/spims_slave_model.sv
// Purpose: mode 0 slave that answers the master byte by byte
// Assumes: always selected; reply is loaded before the first falling edge
// Notes: after the last bit the line keeps changing, so stale data never looks right
module spims_slave_model (
   input wire logic i_sck, // serial clock from the master
   input wire logic i_load, // load a reply byte
   input wire logic [7:0] i_reply, // reply byte
   output logic o_miso // serial data to the master
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] shreg;
   // reply leaves top bit first while the master shifts
   always @(negedge i_sck or posedge i_load)
   begin
      if (i_load)
         shreg <= i_reply;
      else
         shreg <= {shreg[6:0], ~shreg[7]};
   end
   assign o_miso = shreg[7];
endmodule : spims_slave_model

// ### dv/spims_master_asserts.sv
// Purpose: port checks on the select-mode serial master
// Assumes: one clock domain, reset active high
// Notes: the synchronised select level is hidden, so the fault is judged by its flag
module spims_master_asserts (
   input wire logic i_core_clk, // core clock
   input wire logic i_rst, // reset
   input wire logic i_irq_enable, // irq enable
   input wire logic i_enable_wr, // enable write strobe
   input wire logic o_sck, // serial clock
   input wire logic o_busy, // busy
   input wire logic [7:0] o_rx_data, // receive buffer
   input wire logic o_transfer_done_flag, // done flag
   input wire logic o_mode_fault_flag, // fault flag
   input wire logic o_master_enable_bit, // master enable
   input wire logic o_port_enable_bit, // port enable
   input wire logic o_select_mode_hi, // upper mode bit
   input wire logic o_select_mode_lo, // lower mode bit
   input wire logic o_slave_select, // select out
   input wire logic o_slave_select_oe, // select enable
   input wire logic o_irq // interrupt
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   done_irq_a: assert property ($rose(o_transfer_done_flag) && $past(i_irq_enable) |-> o_irq)
      else $error("done set without irq");
   byte_len_a: assert property ($rose(o_busy) |-> ##64 (!o_busy && o_transfer_done_flag))
      else $error("byte not 64 cycles");
   sck_idle_a: assert property (!o_busy |-> !o_sck)
      else $error("sck moves while idle");
   rx_load_a: assert property ($changed(o_rx_data) |-> $past(o_busy) && !o_busy && o_transfer_done_flag)
      else $error("rx changed off a byte end");
   fault_off_a: assert property ($rose(o_mode_fault_flag) |->
      !o_master_enable_bit && !o_port_enable_bit && !o_busy && !o_select_mode_hi && o_select_mode_lo)
      else $error("fault left port on");
   fault_irq_a: assert property ($rose(o_mode_fault_flag) && $past(i_irq_enable) |-> o_irq)
      else $error("fault without irq");
   stay_off_a: assert property ($rose(o_port_enable_bit) |-> $past(i_enable_wr))
      else $error("enable without write");
   four_wire_a: assert property (o_select_mode_hi && $past(o_select_mode_hi) |->
      o_slave_select_oe && o_slave_select == $past(o_select_mode_lo))
      else $error("select out wrong");
   select_in_a: assert property (!o_select_mode_hi && !$past(o_select_mode_hi) |-> !o_slave_select_oe)
      else $error("select driven");
   cover property ($rose(o_mode_fault_flag));
   cover property ($rose(o_transfer_done_flag) && o_irq);
   cover property (o_slave_select_oe && !o_slave_select);
endmodule : spims_master_asserts
bind spims_master spims_master_asserts u_spims_master_asserts (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_irq_enable(i_irq_enable), .i_enable_wr(i_enable_wr), .o_sck(o_sck), .o_busy(o_busy),
   .o_rx_data(o_rx_data), .o_transfer_done_flag(o_transfer_done_flag), .o_mode_fault_flag(o_mode_fault_flag),
   .o_master_enable_bit(o_master_enable_bit), .o_port_enable_bit(o_port_enable_bit),
   .o_select_mode_hi(o_select_mode_hi), .o_select_mode_lo(o_select_mode_lo),
   .o_slave_select(o_slave_select), .o_slave_select_oe(o_slave_select_oe), .o_irq(o_irq));

// ### dv/spims_master_tb.sv
// Purpose: self-checking bench for the select-mode serial master
// Assumes: 100 MHz core clock; slave model always selected
// Notes: random bytes from a fixed seed, with all-zero and all-one bytes first
module spims_master_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk, i_rst, i_start, i_mode_wr, i_select_mode_hi, i_select_mode_lo, i_enable_wr;
   logic i_master_enable_bit, i_port_enable_bit, i_irq_enable, i_clr_done, i_clr_fault, i_miso;
   logic i_slave_select, o_sck, o_mosi, o_slave_select, o_slave_select_oe, o_busy, o_transfer_done_flag;
   logic o_mode_fault_flag, o_master_enable_bit, o_port_enable_bit, o_select_mode_hi, o_select_mode_lo;
   logic o_irq, load;
   logic [7:0] i_tx_data, o_rx_data, reply, mosi_cap;
   int err_total, checks, sck_cnt;
   spims_master u_spims_master (.*);
   spims_slave_model u_spims_slave_model (.i_sck(o_sck), .i_load(load), .i_reply(reply), .o_miso(i_miso));
   // clock, 10 ns period
   initial
   begin
      i_core_clk = 0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // capture what the master sends, sampled where the slave would take it
   always @(posedge o_sck)
   begin
      sck_cnt++;
      mosi_cap <= {mosi_cap[6:0], o_mosi};
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one strobe then a settle gap; mode=1 writes the select bits, else the enables
   task automatic wr(input logic mode, input logic a, input logic b);
      @(posedge i_core_clk);
      {i_mode_wr, i_enable_wr} <= {mode, !mode};
      {i_select_mode_hi, i_select_mode_lo, i_master_enable_bit, i_port_enable_bit} <= {a, b, a, b};
      @(posedge i_core_clk);
      {i_mode_wr, i_enable_wr} <= 2'h0;
      repeat (3) @(posedge i_core_clk);
      #1;
   endtask : wr
   task automatic pulse_start_refused();
      @(posedge i_core_clk);
      i_start <= 1;
      @(posedge i_core_clk);
      i_start <= 0;
      @(posedge i_core_clk);
      #1;
      chk(o_busy, 0);
   endtask : pulse_start_refused
   task automatic xfer(input logic [7:0] tx, input logic [7:0] rp);
      int n = 0;
      @(posedge i_core_clk);
      {reply, i_tx_data, load, i_start} <= {rp, tx, 2'h3};
      sck_cnt = 0;
      @(posedge i_core_clk);
      {load, i_start} <= 2'h0;
      #1;
      // bounded wait; a byte takes 64 cycles
      while (o_busy === 1'b1 && n < 100)
      begin
         @(posedge i_core_clk);
         #1;
         n++;
      end
      chk(8'(n), 8'h40);
      if (n >= 100)
         print_verdict();
      chk(o_rx_data, rp);
      chk(mosi_cap, tx);
      chk(8'(sck_cnt), 8'h08);
      chk({o_transfer_done_flag, o_irq}, {1'b1, i_irq_enable});
      @(posedge i_core_clk);
      i_clr_done <= 1;
      @(posedge i_core_clk);
      i_clr_done <= 0;
      #1;
      chk({o_transfer_done_flag, o_irq}, 0);
      $display("byte %h/%h done", tx, rp);
   endtask : xfer
   initial
   begin
      {i_start, i_mode_wr, i_select_mode_hi, i_select_mode_lo, i_enable_wr, load} = 0;
      {i_master_enable_bit, i_port_enable_bit, i_irq_enable, i_clr_done, i_clr_fault} = 0;
      {i_tx_data, reply, i_slave_select, i_rst} = {16'h0, 2'h3};
      void'($urandom(32'h10e9a04c));
      repeat (16) @(posedge i_core_clk);
      i_rst <= 0;
      @(posedge i_core_clk);
      #1;
      chk({o_select_mode_hi, o_select_mode_lo, o_master_enable_bit, o_port_enable_bit}, 8'h04);
      pulse_start_refused();
      wr(0, 1, 1);
      i_irq_enable <= 1;
      xfer(8'h00, 8'hff);
      xfer(8'hff, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         i_irq_enable <= 1'($urandom);
         xfer(8'($urandom), 8'($urandom));
      end
      $display("random bytes done");
      wr(1, 0, 0);
      i_slave_select <= 0;
      chk(o_slave_select_oe, 0);
      // the model stands for a slave picked by a general-purpose pin, not by the port
      xfer(8'h5a, 8'hc3);
      chk(o_mode_fault_flag, 0);
      for (int k = 0; k < 2; k++)
      begin
         wr(1, 1, k[0]);
         chk({o_slave_select_oe, o_slave_select}, {1'b1, k[0]});
      end
      $display("select modes done");
      i_slave_select <= 1;
      i_irq_enable <= 1;
      // let the high select pass the synchroniser before entering multi-master mode
      repeat (5) @(posedge i_core_clk);
      wr(1, 0, 1);
      chk(o_mode_fault_flag, 0);
      i_slave_select <= 0;
      repeat (8) @(posedge i_core_clk);
      #1;
      chk({o_mode_fault_flag, o_master_enable_bit, o_port_enable_bit, o_irq}, 8'h09);
      i_slave_select <= 1;
      repeat (5) @(posedge i_core_clk);
      pulse_start_refused();
      i_clr_fault <= 1;
      wr(0, 1, 1);
      i_clr_fault <= 0;
      chk({o_mode_fault_flag, o_irq}, 0);
      xfer(8'h81, 8'h7e);
      $display("mode fault done");
      print_verdict();
   end
endmodule : spims_master_tb
